/* File: hdl/general_timer_module.v */
// Purpose: Four channel capture/compare timer with pulse accumulator
// Assumes: clk 250 MHz, rst asynchronous active high, no register bus
// Notes:   Configuration arrives as plain ports; pins are synchronised here
//
// Functional notes
// - 16-bit up counter, seven-stage prescaler
// - Four channels, each capture or compare
// - Channel 3 may feed pulse accumulator
// - Counter overflow is signalled
// - Capture latches counter on chosen edge
// - Compare match drives output or flags
// - Capture and compare channels run concurrently
// - 16-bit accumulator: events or gated time
`timescale 1ns/1ns
`include "timer_defs.vh"

module general_timer_module #(
    parameter W     = `CNT_W,
    parameter NCH   = `NUM_CH,
    parameter PRE_W = `PRE_STAGES
) (
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst,
    // Global control
    input  wire                 timer_enable,
    input  wire [`PRE_SEL_W-1:0] prescale_sel,
    input  wire                 overflow_clear,
    input  wire                 overflow_irq_enable,
    // Channel control, one field per channel
    input  wire [NCH-1:0]       capture_mode,
    input  wire [2*NCH-1:0]     edge_sel,
    input  wire [2*NCH-1:0]     action,
    input  wire [W*NCH-1:0]     compare_value,
    input  wire [NCH-1:0]       flag_clear,
    // Pulse accumulator control
    input  wire                 acc_enable,
    input  wire                 acc_gated,
    input  wire                 acc_edge_fall,
    input  wire                 acc_clear,
    // Pins
    input  wire [NCH-1:0]       timer_pin_in,
    output reg  [NCH-1:0]       timer_pin_out,
    output reg  [NCH-1:0]       timer_pin_oe,
    // Status
    output reg  [W-1:0]         count,
    output reg  [W*NCH-1:0]     capture_value,
    output reg  [NCH-1:0]       channel_flag,
    output reg                  overflow_flag,
    output reg                  overflow_irq,
    output reg  [W-1:0]         acc_count
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [NCH-1:0] pin_meta;
reg [NCH-1:0] pin_sync;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        pin_meta <= {NCH{1'b0}};
        pin_sync <= {NCH{1'b0}};
    end else begin
        pin_meta <= timer_pin_in;
        pin_sync <= pin_meta;
    end
end

// ----------------------------------------
// Prescaler
// ----------------------------------------
reg  [PRE_W-1:0] pre_cnt;
reg              pre_tick;
wire [PRE_W:0]   pre_mask = ({{PRE_W{1'b0}}, 1'b1} << prescale_sel) - 1'b1;
wire [PRE_W-1:0] pre_lim  = pre_mask[PRE_W-1:0];

always @(posedge clk or posedge rst) begin
    if (rst) begin
        pre_cnt  <= {PRE_W{1'b0}};
        pre_tick <= 1'b0;
    end else if (!timer_enable) begin
        pre_cnt  <= {PRE_W{1'b0}};
        pre_tick <= 1'b0;
    end else if (pre_cnt >= pre_lim) begin
        pre_cnt  <= {PRE_W{1'b0}};
        pre_tick <= 1'b1;
    end else begin
        pre_cnt  <= pre_cnt + 1'b1;
        pre_tick <= 1'b0;
    end
end

// ----------------------------------------
// Main counter and overflow
// ----------------------------------------
wire wrap = pre_tick & (count == `CNT_MAX);

always @(posedge clk or posedge rst) begin
    if (rst) begin
        count         <= `CNT_RST;
        overflow_flag <= 1'b0;
        overflow_irq  <= 1'b0;
    end else begin
        if (pre_tick) begin
            count <= count + 1'b1;
        end
        if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (overflow_clear) begin
            overflow_flag <= 1'b0;
        end
        overflow_irq <= (overflow_flag | wrap) & overflow_irq_enable;
    end
end

// ----------------------------------------
// Channels
// ----------------------------------------
wire [W*NCH-1:0] ch_cap;
wire [NCH-1:0]   ch_flag;
wire [NCH-1:0]   ch_wave;
wire [NCH-1:0]   ch_in_use;

genvar g;
generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
        // Channel 3 leaves capture/compare when accumulating
        assign ch_in_use[g] = ~(acc_enable && (g == `ACC_CH));

        timer_channel #(
            .W(W)
        ) u_ch (
            .clk           (clk),
            .rst           (rst),
            .capture_mode  (capture_mode[g]),
            .edge_sel      (ch_in_use[g] ? edge_sel[2*g+1:2*g] : `EDGE_NONE),
            .action        (ch_in_use[g] ? action[2*g+1:2*g] : `ACT_NONE),
            .compare_value (compare_value[W*g+W-1:W*g]),
            .flag_clear    (flag_clear[g]),
            .count         (count),
            .count_tick    (pre_tick & ch_in_use[g]),
            .pin_sync      (pin_sync[g]),
            .capture_value (ch_cap[W*g+W-1:W*g]),
            .flag          (ch_flag[g]),
            .wave_out      (ch_wave[g])
        );
    end
endgenerate

// ----------------------------------------
// Registered pin and status outputs
// ----------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        timer_pin_out <= {NCH{1'b0}};
        timer_pin_oe  <= {NCH{1'b0}};
        capture_value <= {W*NCH{1'b0}};
        channel_flag  <= {NCH{1'b0}};
    end else begin
        timer_pin_out <= ch_wave;
        timer_pin_oe  <= ~capture_mode & ch_in_use;
        capture_value <= ch_cap;
        channel_flag  <= ch_flag;
    end
end

// ----------------------------------------
// Pulse accumulator
// ----------------------------------------
reg  acc_prev;
wire acc_pin  = pin_sync[`ACC_CH];
wire acc_edge = acc_edge_fall ? (acc_prev & ~acc_pin) : (~acc_prev & acc_pin);
wire acc_gate = acc_edge_fall ? ~acc_pin : acc_pin;
wire acc_inc  = acc_gated ? (acc_gate & pre_tick) : acc_edge;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        acc_prev  <= 1'b0;
        acc_count <= `CNT_RST;
    end else begin
        acc_prev <= acc_pin;
        if (acc_clear) begin
            acc_count <= `CNT_RST;
        end else if (acc_enable && acc_inc) begin
            acc_count <= acc_count + 1'b1;
        end
    end
end

endmodule // general_timer_module

/* File: hdl/timer_defs.vh */
// Purpose: Constants for the four channel capture/compare timer
// Assumes: Single clock, no software register bus
// Notes:   Included by the timer design files
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CNT_W        16
`define PRE_STAGES   7
`define PRE_SEL_W    3
`define NUM_CH       4
`define ACC_CH       3

// ----------------------------------------
// Reset and wrap values
// ----------------------------------------
`define CNT_RST      16'h0000
`define CNT_MAX      16'hFFFF

// ----------------------------------------
// Capture edge select codes
// ----------------------------------------
`define EDGE_NONE    2'h0
`define EDGE_RISE    2'h1
`define EDGE_FALL    2'h2
`define EDGE_BOTH    2'h3

// ----------------------------------------
// Compare output action codes
// ----------------------------------------
`define ACT_NONE     2'h0
`define ACT_TOGGLE   2'h1
`define ACT_CLEAR    2'h2
`define ACT_SET      2'h3

`endif

/* File: hdl/timer_channel.v */
// Purpose: One capture/compare channel of the timer
// Assumes: Pin input already synchronised by the parent
// Notes:   Flags are sticky; a set in the clear cycle wins
`timescale 1ns/1ns
`include "timer_defs.vh"

module timer_channel #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Configuration
    input  wire         capture_mode,
    input  wire [1:0]   edge_sel,
    input  wire [1:0]   action,
    input  wire [W-1:0] compare_value,
    input  wire         flag_clear,
    // Counter and pin
    input  wire [W-1:0] count,
    input  wire         count_tick,
    input  wire         pin_sync,
    // Results
    output reg  [W-1:0] capture_value,
    output reg          flag,
    output reg          wave_out
);

reg  pin_prev;
wire rise = pin_sync & ~pin_prev;
wire fall = ~pin_sync & pin_prev;
wire edge_hit = (edge_sel[0] & rise) | (edge_sel[1] & fall);
wire match = ~capture_mode & count_tick & (count == compare_value);
wire event_hit = capture_mode ? edge_hit : match;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        pin_prev      <= 1'b0;
        capture_value <= {W{1'b0}};
        flag          <= 1'b0;
        wave_out      <= 1'b0;
    end else begin
        pin_prev <= pin_sync;
        if (capture_mode && edge_hit) begin
            capture_value <= count;
        end
        if (event_hit) begin
            flag <= 1'b1;
        end else if (flag_clear) begin
            flag <= 1'b0;
        end
        if (match) begin
            case (action)
                `ACT_TOGGLE: wave_out <= ~wave_out;
                `ACT_CLEAR:  wave_out <= 1'b0;
                `ACT_SET:    wave_out <= 1'b1;
                default:     wave_out <= wave_out;
            endcase
        end
    end
end

endmodule // timer_channel

/* File: bench/pin_source.sv */
// Purpose: Far side of the timer pins
// Assumes: Pins are asynchronous to clk
// Notes:   Moves pins between clock edges
`timescale 1ns/1ns
module pin_source (
    // Request
    input  wire       clk,
    input  wire [3:0] req,
    // Pins
    output reg  [3:0] pin
);
    initial pin = 4'h0;
    always @(negedge clk) pin <= req;
endmodule // pin_source

/* File: bench/timer_chk.sv */
// Purpose: Port assertions for the timer
// Assumes: rst asynchronous, active high
// Notes:   Bound to general_timer_module
`timescale 1ns/1ns
module timer_chk #(
    parameter W = 16
) (
    // Control
    input wire           clk, rst, timer_enable, overflow_clear, overflow_irq_enable,
    input wire           acc_enable, acc_clear,
    input wire [2:0]     prescale_sel,
    input wire [3:0]     capture_mode, flag_clear,
    // Status
    input wire [3:0]     timer_pin_oe, channel_flag,
    input wire           overflow_flag, overflow_irq,
    input wire [W-1:0]   count, acc_count,
    input wire [4*W-1:0] capture_value
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_step; (timer_enable && prescale_sel == 3'h0)[*3] |=> count == $past(count) + 1'b1; endproperty
    a_step: assert property (p_step) else $error("count step");
    property p_oe_mode; !$past(rst) |=> timer_pin_oe[1] == !$past(capture_mode[1]); endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("pin enable");
    property p_oe_acc; acc_enable && !$past(rst) |=> !timer_pin_oe[3]; endproperty
    a_oe_acc: assert property (p_oe_acc) else $error("acc pin enable");
    property p_wrap; count == 16'h0000 && $past(count) == 16'hFFFF |-> overflow_flag; endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag");
    property p_cap_hold; !capture_mode[0] [*4] |-> $stable(capture_value[15:0]); endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture moved");
    property p_flag_keep; channel_flag[0] && !flag_clear[0] && !$past(flag_clear[0]) |=> channel_flag[0]; endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
    property p_acc_clr; acc_clear |=> acc_count == 16'h0000; endproperty
    a_acc_clr: assert property (p_acc_clr) else $error("acc clear");
    property p_ovf_keep; overflow_flag && !overflow_clear |=> overflow_flag; endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost");
    property p_irq; overflow_flag && overflow_irq_enable |=> overflow_irq; endproperty
    a_irq: assert property (p_irq) else $error("no request");
    c_wrap: cover property (overflow_flag);
    c_cap: cover property (!$stable(capture_value[31:16]));
    c_acc: cover property (acc_count == 16'h0002);
endmodule // timer_chk
bind general_timer_module timer_chk #(.W(W)) u_chk (.clk(clk), .rst(rst),
    .timer_enable(timer_enable), .overflow_clear(overflow_clear),
    .overflow_irq_enable(overflow_irq_enable), .acc_enable(acc_enable),
    .acc_clear(acc_clear), .prescale_sel(prescale_sel), .capture_mode(capture_mode),
    .flag_clear(flag_clear), .timer_pin_oe(timer_pin_oe), .channel_flag(channel_flag),
    .overflow_flag(overflow_flag), .overflow_irq(overflow_irq), .count(count),
    .acc_count(acc_count), .capture_value(capture_value));

/* File: bench/general_timer_module_tb.sv */
// Purpose: Self-checking bench for the timer
// Assumes: 250 MHz clock, divide by 128 slots
// Notes:   Events sit mid-slot, away from ticks
`timescale 1ns/1ns
`include "timer_defs.vh"
module general_timer_module_tb;
    reg         clk, rst, timer_enable, overflow_clear, acc_gated, acc_clear;
    reg  [2:0]  prescale_sel;
    reg  [3:0]  req, flag_clear;
    wire [3:0]  flg;
    reg  [15:0] v;
    reg  [33:0] m, last;
    reg  [33:0] q [$];
    wire [3:0]  pin, pout;
    wire [15:0] cnt, acc;
    wire [63:0] cap;
    wire        ovf, irq;
    wire [33:0] obs = {ovf, acc, pout[0], cap[31:16]};
    integer     error_cnt = 0, samples_checked = 0, s, i;
    pin_source u_pins (.clk(clk), .req(req), .pin(pin));
    general_timer_module dut (.clk(clk), .rst(rst), .timer_enable(timer_enable),
        .prescale_sel(prescale_sel), .overflow_clear(overflow_clear),
        .overflow_irq_enable(1'b1), .capture_mode(4'h2), .edge_sel({4'h0, `EDGE_RISE, 2'h0}),
        .action({6'h0, `ACT_SET}), .compare_value({48'h0, v}), .flag_clear(flag_clear),
        .acc_enable(1'b1), .acc_gated(acc_gated), .acc_edge_fall(1'b0),
        .acc_clear(acc_clear), .timer_pin_in(pin), .timer_pin_out(pout), .timer_pin_oe(),
        .count(cnt), .capture_value(cap), .channel_flag(flg), .overflow_flag(ovf),
        .overflow_irq(irq), .acc_count(acc));
    task fail(input string msg);
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d errors %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Scoreboard: each output change takes the oldest note
    always @(negedge clk) begin
        if (!rst && obs !== last) begin
            last = obs;
            samples_checked = samples_checked + 1;
            if (q.size() == 0) fail("unexpected change");
            else if (q.pop_front() !== obs) fail("result differs");
        end
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst, timer_enable, overflow_clear, acc_gated, acc_clear} = 5'h10;
        prescale_sel = 3'h7; req = 4'h0; m = 34'h0; last = 34'h0; flag_clear = 4'h0;
        v = $urandom(19779);
        v = 16'h2 + v % 4;
        tick(10);
        rst <= 1'b0;
        tick(2);
        timer_enable <= 1'b1;
        tick(64);
        for (s = 0; s < 13; s = s + 1) begin
            req[1] <= s % 2;
            if (s % 2) begin m[15:0] = s[15:0]; q.push_back(m); end
            if (s == 2 || s == 6) begin req[3] <= 1'b1; m[32:17] = m[32:17] + 16'h1; q.push_back(m); end
            if (s == 4 || s == 7) req[3] <= 1'b0;
            if (s == 5) acc_gated <= 1'b1;
            if (s == 10) begin acc_clear <= 1'b1; m[32:17] = 16'h0; q.push_back(m); end
            if (s == v) begin m[16] = 1'b1; q.push_back(m); end
            tick(1);
            acc_clear <= 1'b0;
            tick(127);
        end
        $display("capture compare accumulate done");
        prescale_sel <= 3'h0;
        m[33] = 1'b1; q.push_back(m);
        i = 0;
        while (ovf !== 1'b1 && i < 70000) begin @(negedge clk); i = i + 1; end
        if (i == 70000) begin fail("no overflow"); complete_run; end
        @(negedge clk); @(negedge clk);
        samples_checked = samples_checked + 1;
        if (irq !== 1'b1) fail("no overflow request");
        @(posedge clk);
        overflow_clear <= 1'b1; m[33] = 1'b0; q.push_back(m);
        tick(1);
        overflow_clear <= 1'b0;
        tick(8);
        samples_checked = samples_checked + 1;
        if (q.size() != 0) fail("results missing");
        $display("overflow done");
        samples_checked = samples_checked + 1;
        if (flg !== 4'h7) fail("channel flags not set");
        flag_clear <= 4'hF;
        tick(1);
        flag_clear <= 4'h0;
        tick(3);
        samples_checked = samples_checked + 1;
        if (flg !== 4'h0) fail("channel flags not cleared");
        $display("flag clear done");
        complete_run;
    end
endmodule // general_timer_module_tb
